// file: design/ccm_pkg.sv
// constants and helpers for the charger config and monitor register bank
package ccm_pkg;
  localparam logic [7:0] ADDR_CURRENT_LIMIT_PIN_UV = 8'h09;
  localparam logic [7:0] ADDR_MON = 8'h0A;
  localparam logic [7:0] ADDR_DPM_TMR = 8'h0B;
  localparam logic [7:0] RST_CURRENT_LIMIT_PIN_UV = 8'h0B;
  localparam logic [7:0] RST_MON = 8'h00;
  localparam logic [7:0] RST_DPM_TMR = 8'h42;
  localparam logic [7:0] MASK_CURRENT_LIMIT_PIN_UV = 8'h3F;
  localparam logic [7:0] MASK_MON = 8'h7C;
  localparam logic [7:0] MASK_DPM_TMR = 8'hFE;
  localparam int RESET_BIT = 7;
  localparam int CURRENT_LIMIT_PIN_LSB = 3;
  localparam int UV_LSB = 0;
  localparam int TRIG_BIT = 7;
  localparam int BAND_LSB = 5;
  localparam int STEP_LSB = 2;
  localparam int DPM_DIS_BIT = 7;
  localparam int DPM_LSB = 4;
  localparam int HALF_BIT = 3;
  localparam int TMR_LSB = 1;
  localparam logic [9:0] CURRENT_LIMIT_PIN_BASE_MA = 10'h032;
  localparam logic [9:0] CURRENT_LIMIT_PIN_STEP_MA = 10'h032;
  localparam logic [12:0] DPM_BASE_MV = 13'h1068;
  localparam logic [12:0] DPM_STEP_MV = 13'h0064;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECOND_NS = 1000000000;
  localparam int SECOND_CYC = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [15:0] LIMIT_30MIN_S = 16'h0708;
  localparam logic [15:0] LIMIT_3H_S = 16'h2A30;
  localparam logic [15:0] LIMIT_9H_S = 16'h7E90;
  localparam logic [1:0] TMR_OFF = 2'h3;
  localparam logic [6:0] DEV_ADDR = 7'h35; // arbitrary value

  // undervoltage code to millivolts, reserved codes give zero
  function automatic logic [11:0] uv_mv(input logic [2:0] code);
    case (code)
      3'h2: uv_mv = 12'hBB8;
      3'h3: uv_mv = 12'hAF0;
      3'h4: uv_mv = 12'hA28;
      3'h5: uv_mv = 12'h960;
      3'h6, 3'h7: uv_mv = 12'h898;
      default: uv_mv = 12'h000;
    endcase
  endfunction

  // monitor step index 0..4 to code, highest threshold first
  function automatic logic [2:0] step_code(input logic [2:0] idx);
    case (idx)
      3'h0: step_code = 3'h7;
      3'h1: step_code = 3'h6;
      3'h2: step_code = 3'h3;
      3'h3: step_code = 3'h2;
      default: step_code = 3'h1;
    endcase
  endfunction

  typedef enum logic [2:0] {
    MON_IDLE = 3'b001,
    MON_SETTLE = 3'b010,
    MON_DECIDE = 3'b100
  } ccm_mon_state_t;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_BYTE = 4'b0010,
    SER_ACK = 4'b0100,
    SER_MACK = 4'b1000
  } ccm_ser_state_t;
endpackage

// file: design/ccm_regbus_if.sv
// register access strobes between the serial front end and the bank
`timescale 1ns/1ps
interface ccm_regbus_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport front (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

// file: design/ccm_serial_slave.sv
// two-wire serial register slave with pointer and auto increment
`timescale 1ns/1ps
module ccm_serial_slave (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  ccm_regbus_if.front bus
);
  import ccm_pkg::*;
  logic [2:0] scl_s_reg, sda_s_reg;
  logic scl_reg, sda_reg;
  logic [7:0] sh_reg, ptr_reg;
  logic [3:0] cnt_reg;
  logic [1:0] byte_reg;
  logic rd_reg, oe_reg, wr_reg;
  ccm_ser_state_t st_reg;
  wire scl_next = (scl_s_reg[1] == scl_s_reg[2]) ? scl_s_reg[2] : scl_reg;
  wire sda_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_reg;
  wire rise = scl_next & ~scl_reg;
  wire fall = ~scl_next & scl_reg;
  wire start = scl_reg & scl_next & sda_reg & ~sda_next;
  wire stop = scl_reg & scl_next & ~sda_reg & sda_next;

  assign sda_oe_out = oe_reg;
  assign bus.wr_stb = wr_reg;
  assign bus.addr = ptr_reg;
  assign bus.wdata = sh_reg;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], sda_in};
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= SER_IDLE;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 4'h0;
      byte_reg <= 2'h0;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (start) begin
        st_reg <= SER_BYTE;
        cnt_reg <= 4'h0;
        byte_reg <= 2'h0;
        rd_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (stop) begin
        st_reg <= SER_IDLE;
        oe_reg <= 1'b0;
      end else begin
        case (st_reg)
          SER_IDLE: begin
            oe_reg <= 1'b0;
          end
          SER_BYTE: begin
            if (rise) begin
              cnt_reg <= cnt_reg + 4'h1;
              sh_reg <= rd_reg ? {sh_reg[6:0], 1'b0} : {sh_reg[6:0], sda_reg};
            end else if (fall && rd_reg) begin
              oe_reg <= (cnt_reg == 4'h8) ? 1'b0 : ~sh_reg[7];
              if (cnt_reg == 4'h8) begin
                st_reg <= SER_MACK;
              end
            end else if (fall && cnt_reg == 4'h8) begin
              oe_reg <= 1'b1;
              st_reg <= SER_ACK;
              if (byte_reg == 2'h0) begin
                rd_reg <= sh_reg[0];
                if (sh_reg[7:1] != DEV_ADDR) begin
                  oe_reg <= 1'b0;
                  st_reg <= SER_IDLE;
                end
              end else if (byte_reg == 2'h1) begin
                ptr_reg <= sh_reg;
              end else begin
                wr_reg <= 1'b1;
              end
              if (byte_reg != 2'h2) begin
                byte_reg <= byte_reg + 2'h1;
              end
            end
          end
          SER_ACK: begin
            if (fall) begin
              cnt_reg <= 4'h0;
              st_reg <= SER_BYTE;
              oe_reg <= 1'b0;
              // pointer moves after the write strobe has been used
              if (byte_reg == 2'h2 && wr_reg == 1'b0 && !rd_reg && sh_reg == bus.wdata) begin
                ptr_reg <= ptr_reg;
              end
              if (rd_reg) begin
                sh_reg <= bus.rdata;
                oe_reg <= ~bus.rdata[7];
                ptr_reg <= ptr_reg + 8'h01;
              end
            end else if (byte_reg == 2'h2 && !rd_reg && wr_reg) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
          SER_MACK: begin
            if (rise && sda_reg) begin
              st_reg <= SER_IDLE;
            end else if (rise) begin
              st_reg <= SER_ACK;
            end
          end
          default: st_reg <= SER_IDLE;
        endcase
      end
    end
  end
endmodule // ccm_serial_slave

// file: design/ccm_charger_regs.sv
// charger limit, monitor and timer register bank with serial access
// How it works
// - writing reset bit restores all defaults
// - input limit is 50 mA per step
// - resistor setting may override default limit
// - undervoltage code maps to fixed voltages
// - monitor trigger bit starts new search
// - band field reports fraction of regulation
// - step field reports position within band
// - search bands downward, else write zero
// - dpm disable bit, zero enables after reset
// - safety timer half rate outside cc/cv
// - timer field selects limit or disables
`timescale 1ns/1ps
module ccm_charger_regs #(
  parameter int TICK_CYC = ccm_pkg::SECOND_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic current_limit_pin_pin_present_in,
  input wire logic [9:0] current_limit_pin_pin_ma_in,
  input wire logic low_power_req_in,
  input wire logic battery_above_in,
  input wire logic charge_active_in,
  input wire logic charge_cc_cv_in,
  output logic [1:0] monitor_band_sel_out,
  output logic [2:0] monitor_step_sel_out,
  output logic monitor_busy_out,
  output logic [9:0] input_limit_ma_out,
  output logic [11:0] battery_undervoltage_mv_out,
  output logic input_dpm_enable_out,
  output logic [12:0] input_dpm_threshold_mv_out,
  output logic safety_expired_out
);
  import ccm_pkg::*;
  ccm_regbus_if bus ();
  logic [7:0] current_limit_pin_uv_reg, mon_reg, dpm_tmr_reg;
  logic current_limit_pin_written_reg, sda_reg;
  logic [2:0] cmp_s_reg;
  ccm_mon_state_t mon_st_reg;
  logic [1:0] band_reg;
  logic [2:0] idx_reg;
  // step code and busy are kept in flops so the outputs carry no decode
  logic [2:0] step_reg;
  logic busy_reg;
  logic [4:0] settle_reg;
  logic [31:0] pre_reg;
  logic half_reg;
  logic [15:0] secs_reg;
  logic [9:0] current_limit_pin_ma_reg;
  logic [11:0] uv_mv_reg;
  logic dpm_en_reg;
  logic [12:0] dpm_mv_reg;
  logic expired_reg;

  ccm_serial_slave u_slave (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .bus(bus.front)
  );

  wire wr_current_limit_pin = bus.wr_stb && bus.addr == ADDR_CURRENT_LIMIT_PIN_UV;
  wire wr_mon = bus.wr_stb && bus.addr == ADDR_MON;
  wire wr_dpm = bus.wr_stb && bus.addr == ADDR_DPM_TMR;
  wire soft_rst = wr_current_limit_pin && bus.wdata[RESET_BIT];
  wire mon_start = (wr_mon && bus.wdata[TRIG_BIT]) || low_power_req_in;
  // reset and trigger bits are never stored, so they read zero
  assign bus.rdata = (bus.addr == ADDR_CURRENT_LIMIT_PIN_UV) ? (current_limit_pin_uv_reg & MASK_CURRENT_LIMIT_PIN_UV) :
                     (bus.addr == ADDR_MON) ? (mon_reg & MASK_MON) :
                     (bus.addr == ADDR_DPM_TMR) ? (dpm_tmr_reg & MASK_DPM_TMR) : 8'h00;

  wire [2:0] current_limit_pin_code = current_limit_pin_uv_reg[CURRENT_LIMIT_PIN_LSB +: 3];
  wire [9:0] current_limit_pin_ma = CURRENT_LIMIT_PIN_BASE_MA + 10'(current_limit_pin_code) * CURRENT_LIMIT_PIN_STEP_MA;
  // the resistor only supersedes the default, a host write takes priority
  wire [9:0] current_limit_pin_eff = (current_limit_pin_pin_present_in && !current_limit_pin_written_reg) ? current_limit_pin_pin_ma_in : current_limit_pin_ma;
  wire [12:0] dpm_mv = DPM_BASE_MV + 13'(dpm_tmr_reg[DPM_LSB +: 3]) * DPM_STEP_MV;
  wire [1:0] tmr_sel = dpm_tmr_reg[TMR_LSB +: 2];
  wire [15:0] tmr_limit = (tmr_sel == 2'h0) ? LIMIT_30MIN_S : (tmr_sel == 2'h1) ? LIMIT_3H_S : LIMIT_9H_S;
  wire slowed = dpm_tmr_reg[HALF_BIT] && !charge_cc_cv_in;
  wire tick = pre_reg == 32'(TICK_CYC - 1);
  wire count_en = tick && (!slowed || half_reg);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      current_limit_pin_uv_reg <= RST_CURRENT_LIMIT_PIN_UV;
      dpm_tmr_reg <= RST_DPM_TMR;
      current_limit_pin_written_reg <= 1'b0;
    end else if (soft_rst) begin
      current_limit_pin_uv_reg <= RST_CURRENT_LIMIT_PIN_UV;
      dpm_tmr_reg <= RST_DPM_TMR;
      current_limit_pin_written_reg <= 1'b0;
    end else begin
      if (wr_current_limit_pin) begin
        current_limit_pin_uv_reg <= bus.wdata & MASK_CURRENT_LIMIT_PIN_UV;
        current_limit_pin_written_reg <= 1'b1;
      end
      if (wr_dpm) begin
        dpm_tmr_reg <= bus.wdata & MASK_DPM_TMR;
      end
    end
  end

  // comparator is analog, so it is synchronised before use
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmp_s_reg <= 3'h0;
    end else begin
      cmp_s_reg <= {cmp_s_reg[1:0], battery_above_in};
    end
  end
  wire cmp_ok = (cmp_s_reg[1] == cmp_s_reg[2]) && cmp_s_reg[2];

  // settle time covers comparator delay plus the synchroniser
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mon_st_reg <= MON_IDLE;
      mon_reg <= RST_MON;
      band_reg <= 2'h3;
      idx_reg <= 3'h0;
      step_reg <= 3'h7;
      busy_reg <= 1'b0;
      settle_reg <= 5'h00;
    end else if (soft_rst) begin
      mon_st_reg <= MON_IDLE;
      busy_reg <= 1'b0;
      mon_reg <= RST_MON;
    end else begin
      case (mon_st_reg)
        MON_IDLE: begin
          if (mon_start) begin
            band_reg <= 2'h3;
            idx_reg <= 3'h0;
            step_reg <= 3'h7;
            busy_reg <= 1'b1;
            settle_reg <= 5'(SETTLE_CYC - 1);
            mon_st_reg <= MON_SETTLE;
          end
        end
        MON_SETTLE: begin
          if (settle_reg == 5'h00) begin
            mon_st_reg <= MON_DECIDE;
          end else begin
            settle_reg <= settle_reg - 5'h01;
          end
        end
        MON_DECIDE: begin
          settle_reg <= 5'(SETTLE_CYC - 1);
          mon_st_reg <= MON_SETTLE;
          if (cmp_ok) begin
            mon_reg <= {1'b0, band_reg, step_reg, 2'h0};
            mon_st_reg <= MON_IDLE;
            busy_reg <= 1'b0;
          end else if (idx_reg != 3'h4) begin
            idx_reg <= idx_reg + 3'h1;
            step_reg <= step_code(idx_reg + 3'h1);
          end else if (band_reg != 2'h0) begin
            band_reg <= band_reg - 2'h1;
            idx_reg <= 3'h0;
            step_reg <= 3'h7;
          end else begin
            mon_reg <= RST_MON;
            mon_st_reg <= MON_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          mon_st_reg <= MON_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pre_reg <= 32'h0;
      half_reg <= 1'b0;
      secs_reg <= 16'h0000;
      expired_reg <= 1'b0;
    end else if (!charge_active_in || tmr_sel == TMR_OFF) begin
      pre_reg <= 32'h0;
      half_reg <= 1'b0;
      secs_reg <= 16'h0000;
      expired_reg <= 1'b0;
    end else begin
      pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
      if (tick) begin
        half_reg <= ~half_reg;
      end
      if (count_en && secs_reg != tmr_limit) begin
        secs_reg <= secs_reg + 16'h0001;
      end
      if (secs_reg >= tmr_limit) begin
        expired_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_reg <= 1'b0;
      current_limit_pin_ma_reg <= CURRENT_LIMIT_PIN_BASE_MA + CURRENT_LIMIT_PIN_STEP_MA;
      uv_mv_reg <= 12'h000;
      dpm_en_reg <= 1'b1;
      dpm_mv_reg <= DPM_BASE_MV;
    end else begin
      sda_reg <= 1'b0;
      current_limit_pin_ma_reg <= current_limit_pin_eff;
      uv_mv_reg <= uv_mv(current_limit_pin_uv_reg[UV_LSB +: 3]);
      dpm_en_reg <= ~dpm_tmr_reg[DPM_DIS_BIT];
      dpm_mv_reg <= dpm_mv;
    end
  end

  assign sda_out = sda_reg;
  assign monitor_band_sel_out = band_reg;
  assign monitor_step_sel_out = step_reg;
  assign monitor_busy_out = busy_reg;
  assign input_limit_ma_out = current_limit_pin_ma_reg;
  assign battery_undervoltage_mv_out = uv_mv_reg;
  assign input_dpm_enable_out = dpm_en_reg;
  assign input_dpm_threshold_mv_out = dpm_mv_reg;
  assign safety_expired_out = expired_reg;
endmodule // ccm_charger_regs

// file: testbench/ccm_regs_chk.sv
// port-level assertions for the charger register bank
`timescale 1ns/1ps
module ccm_regs_chk #(
  parameter int TICK_CYC = 10
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic low_power_req_in,
  input wire logic charge_active_in,
  input wire logic [1:0] monitor_band_sel_out,
  input wire logic [2:0] monitor_step_sel_out,
  input wire logic monitor_busy_out,
  input wire logic [11:0] battery_undervoltage_mv_out,
  input wire logic [12:0] input_dpm_threshold_mv_out,
  input wire logic safety_expired_out
);
  import ccm_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [31:0] run_cnt_reg;
  logic [31:0] run_cnt_next;
  // unbroken charging time, the safety timer can never beat it
  assign run_cnt_next = charge_active_in ? run_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      run_cnt_reg <= 32'h0;
    else
      run_cnt_reg <= run_cnt_next;
  end
  // three busy cycles, so the reload at search start is not judged
  sequence s_searching;
    monitor_busy_out && $past(monitor_busy_out) && $past(monitor_busy_out, 2);
  endsequence
  sequence s_new_band;
    s_searching ##0 (monitor_band_sel_out != $past(monitor_band_sel_out));
  endsequence
  sequence s_new_step;
    s_searching ##0 $changed(monitor_step_sel_out);
  endsequence
  property p_start;
    low_power_req_in && !monitor_busy_out |-> ##[1:3] monitor_busy_out;
  endproperty
  a_start: assert property (p_start) else $error("search did not start");
  property p_done;
    $rose(monitor_busy_out) |-> ##[1:600] !monitor_busy_out;
  endproperty
  a_done: assert property (p_done) else $error("search did not end");
  property p_band;
    s_new_band |-> monitor_band_sel_out == $past(monitor_band_sel_out) - 2'h1 && monitor_step_sel_out == 3'h7;
  endproperty
  a_band: assert property (p_band) else $error("band did not step down");
  property p_step;
    s_new_step ##0 (monitor_band_sel_out == $past(monitor_band_sel_out)) |->
      monitor_step_sel_out inside {3'h6, 3'h3, 3'h2, 3'h1} && monitor_step_sel_out < $past(monitor_step_sel_out);
  endproperty
  a_step: assert property (p_step) else $error("step order wrong");
  property p_hold;
    s_new_step |=> $stable(monitor_step_sel_out) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("candidate not held");
  property p_dpm;
    input_dpm_threshold_mv_out >= DPM_BASE_MV && input_dpm_threshold_mv_out <= 13'h1324 &&
      (input_dpm_threshold_mv_out - DPM_BASE_MV) % DPM_STEP_MV == 13'h0000;
  endproperty
  a_dpm: assert property (p_dpm) else $error("dpm threshold off grid");
  property p_uv;
    battery_undervoltage_mv_out inside {12'h000, 12'hBB8, 12'hAF0, 12'hA28, 12'h960, 12'h898};
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage value illegal");
  property p_exp_min;
    $rose(safety_expired_out) |-> run_cnt_reg >= 32'(1799 * TICK_CYC);
  endproperty
  a_exp_min: assert property (p_exp_min) else $error("timer expired early");
  property p_exp_clear;
    !charge_active_in [*3] |-> !safety_expired_out;
  endproperty
  a_exp_clear: assert property (p_exp_clear) else $error("expiry kept while idle");
endmodule // ccm_regs_chk

bind ccm_charger_regs ccm_regs_chk #(.TICK_CYC(TICK_CYC)) chk_u (.clk_in, .sys_rst_in, .low_power_req_in,
  .charge_active_in, .monitor_band_sel_out, .monitor_step_sel_out, .monitor_busy_out,
  .battery_undervoltage_mv_out, .input_dpm_threshold_mv_out, .safety_expired_out);

// file: testbench/ccm_host_model.sv
// serial register master standing in for the host processor
`timescale 1ns/1ps
module ccm_host_model (
  input wire logic clk_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_line_out
);
  import ccm_pkg::*;
  logic drive_low = 1'b0;
  // pulled-up wire, low while either side pulls
  assign sda_line_out = ~(drive_low | sda_oe_in);
  initial begin
    scl_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // data moves mid-low so slave sync delay never sees a false start
  task automatic put_bit(input logic b);
    tick(4);
    drive_low = ~b;
    tick(4);
    scl_out = 1'b1;
    tick(8);
    scl_out = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    tick(4);
    drive_low = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(8);
    b = sda_line_out;
    scl_out = 1'b0;
  endtask
  task automatic start();
    drive_low = 1'b0;
    tick(8);
    scl_out = 1'b1;
    tick(8);
    drive_low = 1'b1;
    tick(8);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    drive_low = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(8);
    drive_low = 1'b0;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] d);
    logic ack;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(ack);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic b;
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    start();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 0; i < 8; i++) begin
      get_bit(b);
      d = {d[6:0], b};
    end
    put_bit(1'b1);
    stop();
  endtask
endmodule // ccm_host_model

// file: testbench/charger_config_monitor_regs_test.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ps
module charger_config_monitor_regs_test;
  import ccm_pkg::*;
  localparam int TICK = 10;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, lp_req = 1'b0, active = 1'b0, cc_cv = 1'b1, tgt_none = 1'b0;
  logic [1:0] tgt_band = 2'h0;
  logic [2:0] tgt_step = 3'h1;
  logic [9:0] current_limit_pin_ma = 10'h190;
  logic [1:0] band;
  logic [2:0] step;
  logic [9:0] limit;
  logic [11:0] uv;
  logic [12:0] dpm_mv;
  logic [7:0] v, rd;
  logic busy, dpm_en, expired, sda_oe, scl, sda_pin;
  logic pin_on = 1'b1;
  logic [2:0] codes [5] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1};
  wire sda_line;
  wire above;
  int errors = 0, checks_done = 0;
  integer seed = 72643;
  // comparator stand-in: battery sits exactly at the target band and step
  assign above = !tgt_none && (band < tgt_band || (band == tgt_band && step <= tgt_step));
  ccm_host_model host_u (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_line_out(sda_line));
  ccm_charger_regs #(.TICK_CYC(TICK)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_pin), .sda_oe_out(sda_oe),
    .current_limit_pin_pin_present_in(pin_on), .current_limit_pin_pin_ma_in(current_limit_pin_ma), .low_power_req_in(lp_req), .battery_above_in(above),
    .charge_active_in(active), .charge_cc_cv_in(cc_cv), .monitor_band_sel_out(band), .monitor_step_sel_out(step),
    .monitor_busy_out(busy), .input_limit_ma_out(limit), .battery_undervoltage_mv_out(uv),
    .input_dpm_enable_out(dpm_en), .input_dpm_threshold_mv_out(dpm_mv), .safety_expired_out(expired)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function automatic logic [11:0] exp_uv(input logic [2:0] c);
    return (c < 3'h2) ? 12'h000 : (c > 3'h5) ? 12'h898 : 12'hBB8 - 12'(c - 3'h2) * 12'h0C8;
  endfunction
  task automatic check_defaults();
    logic [7:0] tab [3];
    logic [7:0] got;
    tab = '{8'h0B, 8'h00, 8'h42};
    for (int i = 0; i < 3; i++) begin
      host_u.read_reg(8'(ADDR_CURRENT_LIMIT_PIN_UV + i), got);
      check("default", got, tab[i]);
    end
    check("dpm enable", dpm_en, 1'b1);
    check("dpm threshold", dpm_mv, 13'h11F8);
    check("resistor limit", limit, current_limit_pin_ma);
    check("undervoltage", uv, 12'hAF0);
    check("sda out", sda_pin, 1'b0);
  endtask
  // slack covers expiry past min_cyc, the seconds prescaler restarts from zero with charging
  task automatic wait_exp(input int min_cyc, input int slack);
    int n;
    n = 0;
    tick(min_cyc);
    check("early expiry", expired, 1'b0);
    while (expired !== 1'b1 && n < slack) begin
      tick(1);
      n++;
    end
    check("expiry", expired, 1'b1);
    if (expired !== 1'b1)
      summarize();
  endtask
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    tick(4);
    check_defaults();
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 1'($random(seed)), i[2:0], 3'(7 - i)};
      host_u.write_reg(ADDR_CURRENT_LIMIT_PIN_UV, v);
      check("input limit", limit, 10'h032 + 10'(i) * 10'h032);
      check("undervoltage", uv, exp_uv(v[2:0]));
      host_u.read_reg(ADDR_CURRENT_LIMIT_PIN_UV, rd);
      check("reg 09", rd, v & 8'h3F);
    end
    host_u.read_reg(8'h1F, rd);
    check("unmapped", rd, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], 4'($random(seed))};
      host_u.write_reg(ADDR_DPM_TMR, v);
      check("dpm enable", dpm_en, !v[7]);
      check("dpm threshold", dpm_mv, 13'h1068 + 13'(i) * 13'h0064);
      host_u.read_reg(ADDR_DPM_TMR, rd);
      check("reg 0B", rd, v & 8'hFE);
    end
    for (int i = 0; i < 6; i++) begin
      tgt_band = (i == 0) ? 2'h3 : (i == 1) ? 2'h0 : 2'($random(seed));
      tgt_step = (i == 0) ? 3'h7 : (i == 1) ? 3'h1 : codes[$unsigned($random(seed)) % 5];
      tgt_none = (i == 2);
      if (i[0]) begin
        lp_req = 1'b1;
        tick(1);
        lp_req = 1'b0;
        tick(3);
      end else
        host_u.write_reg(ADDR_MON, {1'b1, 7'($random(seed))});
      for (int n = 0; n < 700 && busy !== 1'b0; n++)
        tick(1);
      check("search idle", busy, 1'b0);
      if (busy !== 1'b0)
        summarize();
      host_u.read_reg(ADDR_MON, rd);
      check("monitor", rd, tgt_none ? 8'h00 : {1'b0, tgt_band, tgt_step, 2'b00});
    end
    host_u.write_reg(ADDR_CURRENT_LIMIT_PIN_UV, 8'hF2);
    check_defaults();
    pin_on = 1'b0;
    tick(3);
    check("register default limit", limit, 10'h064);
    pin_on = 1'b1;
    cc_cv = 1'b0;
    host_u.write_reg(ADDR_DPM_TMR, 8'h40);
    active = 1'b1;
    wait_exp(1790 * TICK, 30 * TICK);
    host_u.write_reg(ADDR_DPM_TMR, 8'h46);
    check("timer off", expired, 1'b0);
    active = 1'b0;
    host_u.write_reg(ADDR_DPM_TMR, 8'h48);
    active = 1'b1;
    wait_exp(3580 * TICK, 60 * TICK);
    summarize();
  end
endmodule // charger_config_monitor_regs_test
